// ==== sar_pkg.sv ====
// Shared constants and types for the setpoint alarm block
`default_nettype none
package sar_pkg;
    // Reading and delay widths
    localparam int RD_W = 15;
    localparam int DLY_W = 14;
    // Reading range limits, -1999 and 9999
    localparam logic [14:0] RD_MAX = 15'h270f;
    localparam logic [14:0] RD_MIN = 15'h7831;
    // Delay range, 0 to 9999 seconds
    localparam logic [13:0] DLY_MAX = 14'h270f;
    // Reset values and hysteresis band
    localparam logic [14:0] SP_RST = 15'h0000;
    localparam logic [13:0] DLY_RST = 14'h0000;
    localparam logic [3:0] SENSE_RST = 4'hf;
    localparam logic [3:0] HYS_RST = 4'h0;
    localparam logic [14:0] HYSTERESIS_ENABLE_BAND = 15'h0002;
    // Label and value alternate every half second
    localparam int BLINK_MS = 500;
    localparam int CLK_KHZ = 10000;
    localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;

    // Three zone colors
    typedef enum logic [1:0] {
        COL_GREEN = 2'h0,
        COL_ORANGE = 2'h1,
        COL_RED = 2'h2
    } sar_color_t;

    // Menu steps, one-hot
    typedef enum logic [17:0] {
        ST_IDLE = 18'h00001, ST_SP1 = 18'h00002,
        ST_MAKE = 18'h00004, ST_BRK = 18'h00008,
        ST_HYS1 = 18'h00010, ST_PUMP = 18'h00020,
        ST_SP2 = 18'h00040, ST_HYS2 = 18'h00080,
        ST_SP3 = 18'h00100, ST_HYS3 = 18'h00200,
        ST_SP4 = 18'h00400, ST_HYS4 = 18'h00800,
        ST_TRIP = 18'h01000, ST_CBEL = 18'h02000,
        ST_C1 = 18'h04000, ST_C2 = 18'h08000,
        ST_C3 = 18'h10000, ST_C4 = 18'h20000
    } sar_menu_t;

    // Relay and annunciator drive
    typedef struct packed {
        logic [3:0] relay;
        logic [3:0] led;
    } sar_annun_t;

    // Front-panel display hints
    typedef struct packed {
        sar_menu_t menu;
        logic label_phase;
        logic [3:0] flash_digit;
        logic [3:0] dp;
    } sar_disp_t;
endpackage
`default_nettype wire

// ==== sar_setpoint_alarm.sv ====
// Setpoint alarm, relay delays, menu and bargraph zone color
//
// Behaviour
// - All four setpoints evaluated, relay fitted or not
// - Setpoint at range limit never trips
// - Relay one makes after full make delay
// - Relay one breaks after full break delay
// - Setpoints two, three, four follow comparison directly
// - Independent hysteresis enable per setpoint
// - Pump band: setpoint two upper, one lower
// - Pump low sense: on below one, off at two
// - Pump high sense: on above two, off at one
// - High trips above, low trips below setpoint
// - Trip senses stored as four digits, left first
// - Edited sense digit flashes with decimal point
// - Two-button press enters menu, label alternates
// - Program press steps the fixed menu order
// - After last digit: exit or color menu
// - Whole bar shows one zone color
// - Below lowest setpoint shows below color
// - Zone chosen by setpoint value, not number
// - Equal setpoints: highest number wins
// - Three colors per zone: green, orange, red
// - Left means below, right means above
`default_nettype none
module sar_setpoint_alarm #(
    parameter int BLINK_CYC = sar_pkg::BLINK_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Measurement, same clock domain
    input wire logic [14:0] i_reading,
    input wire logic i_sec_tick,
    // Front-panel buttons, raw pins
    input wire logic i_btn_prog,
    input wire logic i_btn_up,
    input wire logic i_btn_down,
    // Fitted display option
    input wire logic i_tricolor,
    // Outputs
    output var sar_pkg::sar_annun_t o_annun,
    output var sar_pkg::sar_color_t o_color,
    output var sar_pkg::sar_disp_t o_disp
);
    // Operator settings
    logic [14:0] sp [4];
    logic [13:0] dly_make;
    logic [13:0] dly_brk;
    logic [3:0] hys;
    logic pump;
    logic [3:0] sense; // bit 0 is the leftmost digit
    sar_pkg::sar_color_t col [5]; // 0 below, 1..4 above
    // Menu state
    sar_pkg::sar_menu_t menu, next_menu, adv;
    logic [1:0] digit, next_digit;
    // Button synchronisers and edge detect
    logic [2:0] bsync1, bsync2, bprev;
    logic combo_prev;
    // Alarm state and relay one timing
    logic [3:0] alm, set_w, clr_w;
    logic relay1;
    logic [13:0] cnt;
    logic [22:0] blink_cnt;
    logic phase;

    // Two flops on pins before any logic reads them
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            bsync1 <= 3'h0;
            bsync2 <= 3'h0;
            bprev <= 3'h0;
            combo_prev <= 1'b0;
        end else begin
            bsync1 <= {i_btn_down, i_btn_up, i_btn_prog};
            bsync2 <= bsync1;
            bprev <= bsync2;
            combo_prev <= bsync2[0] & bsync2[1];
        end
    end

    // Button events; the combo hides single presses
    wire logic combo = bsync2[0] & bsync2[1];
    wire logic combo_edge = combo & ~combo_prev;
    wire logic prog_edge = bsync2[0] & ~bprev[0] & ~bsync2[1];
    wire logic up_edge = bsync2[1] & ~bprev[1] & ~bsync2[0];
    wire logic dn_edge = bsync2[2] & ~bprev[2];

    // Fixed successor in the menu
    function automatic sar_pkg::sar_menu_t succ(
        input sar_pkg::sar_menu_t m);
        case (m)
            sar_pkg::ST_SP1: succ = sar_pkg::ST_MAKE;
            sar_pkg::ST_MAKE: succ = sar_pkg::ST_BRK;
            sar_pkg::ST_BRK: succ = sar_pkg::ST_HYS1;
            sar_pkg::ST_HYS1: succ = sar_pkg::ST_PUMP;
            sar_pkg::ST_PUMP: succ = sar_pkg::ST_SP2;
            sar_pkg::ST_SP2: succ = sar_pkg::ST_HYS2;
            sar_pkg::ST_HYS2: succ = sar_pkg::ST_SP3;
            sar_pkg::ST_SP3: succ = sar_pkg::ST_HYS3;
            sar_pkg::ST_HYS3: succ = sar_pkg::ST_SP4;
            sar_pkg::ST_SP4: succ = sar_pkg::ST_HYS4;
            sar_pkg::ST_HYS4: succ = sar_pkg::ST_TRIP;
            sar_pkg::ST_CBEL: succ = sar_pkg::ST_C1;
            sar_pkg::ST_C1: succ = sar_pkg::ST_C2;
            sar_pkg::ST_C2: succ = sar_pkg::ST_C3;
            sar_pkg::ST_C3: succ = sar_pkg::ST_C4;
            default: succ = sar_pkg::ST_IDLE;
        endcase
    endfunction
    assign adv = succ(menu);

    // Menu stepping
    always_comb begin
        next_menu = menu;
        next_digit = digit;
        case (menu)
            sar_pkg::ST_IDLE: begin
                if (combo_edge) next_menu = sar_pkg::ST_SP1;
            end
            sar_pkg::ST_TRIP: begin
                if (prog_edge && digit == 2'h3) begin
                    next_digit = 2'h0;
                    next_menu = i_tricolor ? sar_pkg::ST_CBEL
                                           : sar_pkg::ST_IDLE;
                end else if (prog_edge) begin
                    next_digit = digit + 2'h1;
                end
            end
            default: begin
                if (prog_edge) next_menu = adv;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            menu <= sar_pkg::ST_IDLE;
            digit <= 2'h0;
        end else begin
            menu <= next_menu;
            digit <= next_digit;
        end
    end

    // Clamped step; range limits stay reachable
    function automatic logic [15:0] bump(input logic [15:0] v,
        input logic [15:0] lo, input logic [15:0] hi, input logic up);
        if (up) bump = ($signed(v) >= $signed(hi)) ? hi : v + 16'h0001;
        else bump = ($signed(v) <= $signed(lo)) ? lo : v - 16'h0001;
    endfunction

    // Next color in the green, orange, red cycle
    function automatic sar_pkg::sar_color_t ncol(
        input sar_pkg::sar_color_t c);
        case (c)
            sar_pkg::COL_GREEN: ncol = sar_pkg::COL_ORANGE;
            sar_pkg::COL_ORANGE: ncol = sar_pkg::COL_RED;
            default: ncol = sar_pkg::COL_GREEN;
        endcase
    endfunction

    // Which setting is under edit
    wire logic edit = up_edge | dn_edge;
    wire logic [1:0] sp_sel = menu[6] ? 2'h1 : menu[8] ? 2'h2 :
                             menu[10] ? 2'h3 : 2'h0;
    wire logic sp_st = menu[1] | menu[6] | menu[8] | menu[10];
    wire logic hys_st = menu[4] | menu[7] | menu[9] | menu[11];
    wire logic [1:0] hys_sel = menu[7] ? 2'h1 : menu[9] ? 2'h2 :
                              menu[11] ? 2'h3 : 2'h0;
    wire logic [2:0] col_sel = menu[14] ? 3'h1 : menu[15] ? 3'h2 :
        menu[16] ? 3'h3 : menu[17] ? 3'h4 : 3'h0;
    wire logic col_st = |menu[17:13];
    wire logic [15:0] sp_step = bump({sp[sp_sel][14], sp[sp_sel]},
        {sar_pkg::RD_MIN[14], sar_pkg::RD_MIN},
        {1'b0, sar_pkg::RD_MAX}, up_edge);
    wire logic [15:0] mk_step = bump({2'h0, dly_make}, 16'h0000,
        {2'h0, sar_pkg::DLY_MAX}, up_edge);
    wire logic [15:0] bk_step = bump({2'h0, dly_brk}, 16'h0000,
        {2'h0, sar_pkg::DLY_MAX}, up_edge);

    // Settings storage, written only from the menu
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            for (int k = 0; k < 4; k++) sp[k] <= sar_pkg::SP_RST;
            for (int k = 0; k < 5; k++) col[k] <= sar_pkg::COL_GREEN;
            dly_make <= sar_pkg::DLY_RST;
            dly_brk <= sar_pkg::DLY_RST;
            hys <= sar_pkg::HYS_RST;
            pump <= 1'b0;
            sense <= sar_pkg::SENSE_RST;
        end else if (edit) begin
            if (sp_st) sp[sp_sel] <= sp_step[14:0];
            if (menu[2]) dly_make <= mk_step[13:0];
            if (menu[3]) dly_brk <= bk_step[13:0];
            if (hys_st) hys[hys_sel] <= ~hys[hys_sel];
            if (menu[5]) pump <= ~pump;
            if (menu[12]) sense[digit] <= ~sense[digit];
            if (col_st) col[col_sel] <= ncol(col[col_sel]);
        end
    end

    // Comparisons at 17 bits so a band never wraps
    wire logic signed [16:0] rd = {{2{i_reading[14]}}, i_reading};
    wire logic signed [16:0] hb = {2'h0, sar_pkg::HYSTERESIS_ENABLE_BAND};
    wire logic signed [16:0] s1 = {{2{sp[0][14]}}, sp[0]};
    wire logic signed [16:0] s2 = {{2{sp[1][14]}}, sp[1]};
    wire logic pump_on = pump & (s2 > s1);
    wire logic pump_set = sense[0] ? rd > s2 : rd < s1;
    wire logic pump_clr = sense[0] ? rd <= s1 : rd >= s2;

    // Every setpoint runs, relay or not
    for (genvar g = 0; g < 4; g++) begin : g_alm
        wire logic signed [16:0] s = {{2{sp[g][14]}}, sp[g]};
        wire logic trip = sense[g] ? rd > s : rd < s;
        wire logic hclr = sense[g] ? rd <= s - hb : rd >= s + hb;
        wire logic clr = hys[g] ? hclr : ~trip;
        if (g == 0) begin : g_pump
            assign set_w[g] = pump_on ? pump_set : trip;
            assign clr_w[g] = pump_on ? pump_clr : clr;
        end else begin : g_plain
            assign set_w[g] = trip;
            assign clr_w[g] = clr;
        end
    end

    // Alarm latch; a set beats a clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) alm <= 4'h0;
        else alm <= set_w | (alm & ~clr_w);
    end

    // Relay one delay: count only while it disagrees
    wire logic pend = alm[0] != relay1;
    wire logic [13:0] lim = relay1 ? dly_brk : dly_make;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            relay1 <= 1'b0;
            cnt <= 14'h0000;
        end else if (!pend) begin
            cnt <= 14'h0000;
        end else if (cnt >= lim) begin
            relay1 <= alm[0];
            cnt <= 14'h0000;
        end else if (i_sec_tick) begin
            cnt <= cnt + 14'h0001;
        end
    end

    // Other relays follow their alarm with no delay
    assign o_annun.relay = {alm[3:1], relay1};
    assign o_annun.led = {alm[3:1], relay1};

    // Zone pick: largest setpoint under the bar, ties to higher
    function automatic sar_pkg::sar_color_t zone(
        input logic signed [16:0] r);
        logic signed [16:0] best;
        logic hit;
        zone = col[0];
        best = 17'h00000;
        hit = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (r > $signed({{2{sp[k][14]}}, sp[k]}) && (!hit ||
                $signed({{2{sp[k][14]}}, sp[k]}) >= best)) begin
                best = {{2{sp[k][14]}}, sp[k]};
                hit = 1'b1;
                zone = col[k+1];
            end
        end
    endfunction

    // Whole bar takes one color; left reads as below
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) o_color <= sar_pkg::COL_GREEN;
        else o_color <= zone(rd);
    end

    // Label and value alternate while in the menu
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || menu[0]) begin
            blink_cnt <= 23'h000000;
            phase <= 1'b1;
        end else if (blink_cnt >= 23'(BLINK_CYC - 1)) begin
            blink_cnt <= 23'h000000;
            phase <= ~phase;
        end else begin
            blink_cnt <= blink_cnt + 23'h000001;
        end
    end

    wire logic [3:0] dsel = menu[12] ? 4'h1 << digit : 4'h0;
    assign o_disp.menu = menu;
    assign o_disp.label_phase = phase;
    assign o_disp.flash_digit = dsel;
    assign o_disp.dp = dsel;

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    property p_make;
        $rose(relay1) |-> $past(alm[0]) && $past(cnt >= dly_make);
    endproperty
    a_make: assert property (p_make)
        else $error("relay one made early");
    property p_break;
        $fell(relay1) |-> !$past(alm[0]) && $past(cnt >= dly_brk);
    endproperty
    a_break: assert property (p_break)
        else $error("relay one broke early");
    property p_restart;
        !pend |=> cnt == 14'h0000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("delay count not restarted");
    property p_direct;
        !hys[2] ##1 !hys[2] |-> o_annun.relay[2] == $past(set_w[2]);
    endproperty
    a_direct: assert property (p_direct)
        else $error("relay three lags comparison");
    property p_limit;
        sense[3] && sp[3] == sar_pkg::RD_MAX |-> !set_w[3];
    endproperty
    a_limit: assert property (p_limit)
        else $error("setpoint at top count tripped");
    property p_enter;
        menu == sar_pkg::ST_IDLE && combo_edge |=>
            menu == sar_pkg::ST_SP1;
    endproperty
    a_enter: assert property (p_enter)
        else $error("combo did not enter menu");
    property p_step;
        menu == sar_pkg::ST_SP1 && prog_edge |=>
            menu == sar_pkg::ST_MAKE ##0 o_disp.flash_digit == 4'h0;
    endproperty
    a_step: assert property (p_step)
        else $error("menu did not step to make delay");
    property p_exit;
        menu == sar_pkg::ST_TRIP && digit == 2'h3 && prog_edge
        |=> menu == (i_tricolor ? sar_pkg::ST_CBEL : sar_pkg::ST_IDLE);
    endproperty
    a_exit: assert property (p_exit)
        else $error("wrong exit from trip digits");
    property p_below;
        rd <= s1 && rd <= s2 && rd <= $signed({{2{sp[2][14]}}, sp[2]})
        && rd <= $signed({{2{sp[3][14]}}, sp[3]}) ##1 $stable(col[0])
        |-> o_color == col[0];
    endproperty
    a_below: assert property (p_below)
        else $error("below color not shown");
    property p_tie;
        sp[3] == sp[0] && rd > s1 && $signed(sp[3]) >= $signed(sp[1])
        && $signed(sp[3]) >= $signed(sp[2]) ##1 $stable(col[4])
        |-> o_color == col[4];
    endproperty
    a_tie: assert property (p_tie)
        else $error("tie not won by setpoint four");

    c_make: cover property ($rose(relay1));
    c_pump: cover property (pump_on && alm[0] && !set_w[0]);
    c_color: cover property (menu == sar_pkg::ST_CBEL);
    c_break: cover property ($fell(relay1) && dly_brk != 14'h0000);
endmodule
`default_nettype wire

// ==== sar_panel_model.sv ====
// Passive panel model: relay drivers, annunciators and bargraph
`default_nettype none
module sar_panel_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Drive coming from the block
    input wire sar_pkg::sar_annun_t i_annun,
    input wire sar_pkg::sar_color_t i_color,
    // Observations for the bench
    output logic [7:0] o_makes,
    output logic o_bad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic relay1_q; // Last relay one state, for edge detection
    logic led_off; // Annunciator disagrees with its relay
    logic col_bad; // Color code outside the three lamps
    assign led_off = i_annun.led != i_annun.relay;
    assign col_bad = i_color == 2'h3;
    // Count relay one makes; a sticky flag catches any bad drive,
    // since a one-cycle glitch would be missed by sampled checks
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_makes <= 8'h00;
            o_bad <= 1'b0;
            relay1_q <= 1'b0;
        end else begin
            relay1_q <= i_annun.relay[0];
            // Rising relay coil drive
            if (i_annun.relay[0] && !relay1_q) begin
                o_makes <= o_makes + 8'h01;
            end
            // The lamp has no fourth color to show
            if (col_bad || led_off) begin
                o_bad <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sar_setpoint_alarm_test.sv ====
// Self-checking bench for the setpoint alarm block
`default_nettype none
module sar_setpoint_alarm_test;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus, all driven on the falling edge
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [14:0] reading = 15'h0000;
    logic sec_tick = 1'b0;
    logic btn_prog = 1'b0;
    logic btn_up = 1'b0;
    logic btn_down = 1'b0;
    logic tricolor = 1'b0;
    // Observed outputs
    sar_pkg::sar_annun_t annun;
    sar_pkg::sar_color_t color;
    sar_pkg::sar_disp_t disp;
    logic [7:0] makes;
    logic bad;
    // Bookkeeping
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    sar_pkg::sar_menu_t steps [20]; // Expected menu order
    int ups [20]; // Up presses made at each menu step

    // Short blink so label alternation is seen quickly
    sar_setpoint_alarm #(.BLINK_CYC(8)) DUT (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_reading(reading),
        .i_sec_tick(sec_tick), .i_btn_prog(btn_prog),
        .i_btn_up(btn_up), .i_btn_down(btn_down),
        .i_tricolor(tricolor), .o_annun(annun), .o_color(color),
        .o_disp(disp));
    sar_panel_model model (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_annun(annun),
        .i_color(color), .o_makes(makes), .o_bad(bad));

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    // Hang guard, far above the few hundred cycles used
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Hold past the two-flop sync, then release fully
    task automatic press(input logic [2:0] b);
        @(negedge clk_sys);
        {btn_prog, btn_up, btn_down} = b;
        repeat (4) @(negedge clk_sys);
        {btn_prog, btn_up, btn_down} = 3'h0;
        repeat (4) @(negedge clk_sys);
    endtask

    // One-cycle seconds pulses, spaced apart
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            sec_tick = 1'b1;
            @(negedge clk_sys);
            sec_tick = 1'b0;
            repeat (3) @(negedge clk_sys);
        end
    endtask

    // New reading, then let the alarm path settle
    task automatic put(input int v);
        @(negedge clk_sys);
        reading = v[14:0];
        repeat (3) @(negedge clk_sys);
    endtask

    // Walk the full menu, editing with up presses from ups
    task automatic walk(input logic tc);
        int n;
        logic ph;
        n = tc ? 20 : 15;
        tricolor = tc;
        press(3'h6);
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                press(3'h4);
            end
            check(disp.menu, steps[i]);
            if (i == 0) begin
                ph = disp.label_phase;
                repeat (8) @(negedge clk_sys);
                check(disp.label_phase, !ph);
            end
            if (i >= 11 && i < 15) begin
                check(disp.flash_digit, 32'h1 << (i - 11));
                check(disp.dp, 32'h1 << (i - 11));
            end
            repeat (ups[i]) press(3'h2);
            // One down step; the color test sees the setpoint land
            if (i == 0 && !tc) begin
                press(3'h1);
            end
        end
        press(3'h4);
        check(disp.menu, sar_pkg::ST_IDLE);
        check(disp.label_phase, 1'b1);
        $display("menu walk done, tricolor %0b", tc);
    endtask

    task automatic test_reset;
        check(annun, 8'h00);
        check(color, sar_pkg::COL_GREEN);
        check(disp.menu, sar_pkg::ST_IDLE);
        check(disp.flash_digit, 4'h0);
        $display("reset test done");
    endtask

    // All setpoints at zero, high sense: every relay follows
    task automatic test_direct;
        put(5);
        check(annun.relay, 4'hf);
        check(annun.led, 4'hf);
        put(-5);
        check(annun.relay, 4'h0);
        $display("direct alarm test done");
    endtask

    // Setpoint one at 3, make 2 s, break 1 s
    task automatic test_delay;
        put(10);
        tick(1);
        check(annun.relay, 4'he);
        put(0);
        put(10);
        tick(1);
        check(annun.relay[0], 1'b0);
        tick(1);
        check(annun.relay[0], 1'b1);
        put(0);
        check(annun.relay, 4'h1);
        tick(1);
        check(annun.relay, 4'h0);
        $display("delay test done");
    endtask

    // Pump band, low sense, band 3 to 6
    task automatic test_pump;
        put(7);
        tick(2);
        check(annun.relay[0], 1'b0);
        put(4);
        tick(2);
        check(annun.relay[0], 1'b0);
        put(2);
        tick(2);
        check(annun.relay[0], 1'b1);
        put(5);
        tick(2);
        check(annun.relay[0], 1'b1);
        put(6);
        tick(1);
        check(annun.led[0], 1'b0);
        $display("pump band test done");
    endtask

    // Setpoint three at 0 with hysteresis, four at 0 without
    task automatic test_hysteresis_enable;
        put(1);
        check(annun.relay[2], 1'b1);
        put(-1);
        check(annun.relay[2], 1'b1);
        check(annun.relay[3], 1'b0);
        put(-2);
        check(annun.relay[2], 1'b0);
        $display("hysteresis test done");
    endtask

    // Setpoints 0,0,3,6 by number 3,4,1,2; equal values counted below
    task automatic test_color;
        int rd [6] = '{-1, 0, 1, 3, 4, 7};
        sar_pkg::sar_color_t ex [6] = '{sar_pkg::COL_RED,
            sar_pkg::COL_RED, sar_pkg::COL_GREEN, sar_pkg::COL_GREEN,
            sar_pkg::COL_ORANGE, sar_pkg::COL_RED};
        for (int i = 0; i < 6; i++) begin
            put(rd[i]);
            check(color, ex[i]);
        end
        check(bad, 1'b0);
        check(makes, 8'h03);
        $display("color test done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        steps = '{sar_pkg::ST_SP1, sar_pkg::ST_MAKE, sar_pkg::ST_BRK,
            sar_pkg::ST_HYS1, sar_pkg::ST_PUMP, sar_pkg::ST_SP2,
            sar_pkg::ST_HYS2, sar_pkg::ST_SP3, sar_pkg::ST_HYS3,
            sar_pkg::ST_SP4, sar_pkg::ST_HYS4, sar_pkg::ST_TRIP,
            sar_pkg::ST_TRIP, sar_pkg::ST_TRIP, sar_pkg::ST_TRIP,
            sar_pkg::ST_CBEL, sar_pkg::ST_C1, sar_pkg::ST_C2,
            sar_pkg::ST_C3, sar_pkg::ST_C4};
        ups = '{default: 0};
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        test_reset();
        test_direct();
        // Setpoint one 3, make 2, break 1, setpoint two 6
        ups[0] = 4;
        ups[1] = 2;
        ups[2] = 1;
        ups[5] = 6;
        walk(1'b0);
        test_delay();
        // Pump on, sense one low, colors red,orange,red,orange,green
        ups = '{default: 0};
        ups[4] = 1;
        ups[8] = 1;
        ups[11] = 1;
        ups[15] = 2;
        ups[16] = 1;
        ups[17] = 2;
        ups[18] = 1;
        walk(1'b1);
        test_pump();
        test_color();
        test_hysteresis_enable();
        report_and_stop();
    end
endmodule
`default_nettype wire
